// [hdl/fcs_clk_div.v]
`timescale 1ns/1ps
`default_nettype none

// Power-of-two divider for a synchronised clock level
module fcs_clk_div (
  input  wire       mclk,
  input  wire       rst,
  input  wire       src_level,
  input  wire [3:0] shift,
  output reg        clk_out
);

  reg       src_d_reg;
  reg [9:0] cnt_reg;

  // Counter bit k toggles every 2^k source edges: divide by 2^(k+1)
  always @(posedge mclk) begin
    if (rst) begin
      src_d_reg <= 1'b0;
      cnt_reg   <= 10'h000;
      clk_out   <= 1'b0;
    end else begin
      src_d_reg <= src_level;
      if (src_level && !src_d_reg) begin
        cnt_reg <= cnt_reg + 10'h001;
      end
      if (shift == 4'h0) begin
        clk_out <= src_level;
      end else begin
        clk_out <= cnt_reg[shift - 4'h1];
      end
    end
  end

endmodule // fcs_clk_div

`default_nettype wire

// [hdl/fcs_defines.vh]
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Register offsets on the 2-bit register port
`define FCS_OFS_SRC_CTRL      2'h0
`define FCS_OFS_OSC_DIV_CTRL  2'h1
`define FCS_OFS_TRIM          2'h2
`define FCS_OFS_RANGE_STATUS  2'h3

// clock_source_control fields
`define FCS_SRC_SEL_HI        7
`define FCS_SRC_SEL_LO        6
`define FCS_REF_DIV_HI        5
`define FCS_REF_DIV_LO        3
`define FCS_REF_SEL_BIT       2
`define FCS_IREF_OE_BIT       1
`define FCS_IREF_STOP_BIT     0

// oscillator_divider_control fields
`define FCS_BUS_DIV_HI        7
`define FCS_BUS_DIV_LO        6
`define FCS_OSC_RANGE_BIT     5
`define FCS_HIGH_GAIN_BIT     4
`define FCS_LOW_POWER_BIT     3
`define FCS_EXT_KIND_BIT      2
`define FCS_EREF_OE_BIT       1
`define FCS_EREF_STOP_BIT     0

// range_status_control fields
`define FCS_RANGE_HI          7
`define FCS_RANGE_LO          6
`define FCS_MAX32_BIT         5
`define FCS_REF_STAT_BIT      4
`define FCS_SRC_STAT_HI       3
`define FCS_SRC_STAT_LO       2
`define FCS_OSC_READY_BIT     1
`define FCS_FINE_TRIM_BIT     0

// Reset values
`define FCS_RST_SRC_CTRL      8'h04
`define FCS_RST_OSC_DIV_CTRL  8'h40
`define FCS_RST_TRIM          8'h80
`define FCS_RST_RANGE         2'h0
`define FCS_RST_FINE_TRIM     1'b0

// Source select and range codes
`define FCS_SRC_FLL           2'h0
`define FCS_SRC_INT           2'h1
`define FCS_SRC_EXT           2'h2
`define FCS_RANGE_RESERVED    2'h3

// Divider shifts: high range starts at divide by 32, 1024 is the top
`define FCS_HIGH_RANGE_SHIFT  4'h5
`define FCS_MAX_SHIFT         4'ha
`define FCS_DEBUG_SHIFT       4'h1

`endif

// [hdl/fcs_top.v]
// Operation
// - Reset enters FLL engaged internal mode, FLL on internal reference.
// - Engaged internal: system clock from FLL on internal ref, debug from FLL.
// - Engaged external: system clock from FLL on external ref, debug from FLL.
// - Bypassed internal: FLL runs on the ref picked by bit 2, system clock from internal ref.
// - Internal low power bypass: internal ref clock, FLL and debug clock off unless debug active.
// - Bypassed external: FLL runs, system clock from external reference.
// - External low power bypass: external ref clock, FLL and debug clock off unless debug active.
// - Stop: FLL off, no system or debug clock, references per setup.
// - Debug clock is the oscillator output divided by two.
// - Source select 00 FLL, 01 internal, 10 external, 11 as 00.
// - Selected source is divided by 1, 2, 4 or 8.
// - Reference divider field in bits 5 to 3 divides the external reference.
// - Low range divides 1 to 128, high range 32 to 1024.
// - Reference select bit 2 feeds FLL internal when set, external else.
// - Internal reference output enable gates the internal reference output.
// - Internal reference runs in stop only if both enables set before stop.
// - Internal reference period is trimmed by nine bits.
// - FLL offers three oscillator ranges.
// - Option maximises FLL output with a 32768 Hz reference.
// - Bus divider codes give 1, 2, 4, 8; divide by two after reset.
// - Low power bit turns FLL off in bypass unless debug active.
// - Range select 00/01/10; writes of 11 or under low power ignored.
// - Larger coarse trim lengthens the internal reference period.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_top (
  input  wire       mclk,
  input  wire       rst,
  input  wire [1:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       stop_req,
  input  wire       debug_active,
  input  wire       int_ref_clk_in,
  input  wire       ext_ref_clk_in,
  input  wire       dco_clk_in,
  input  wire       oscillator_ready_in,
  output reg        bus_clk_out,
  output reg        debug_clk_out,
  output reg        fll_ref_clk_out,
  output reg        internal_ref_clock_out,
  output reg        external_ref_clock_out,
  output reg        fll_enable_out,
  output reg  [1:0] fll_range_out,
  output reg        max_freq_low_ref_option_out,
  output reg  [8:0] trim_out,
  output reg        int_ref_enable_out,
  output reg        osc_enable_out,
  output reg        osc_high_gain_out,
  output reg        osc_range_out,
  output reg        external_source_kind_out,
  output reg  [6:0] mode_out
);

  localparam [6:0] MODE_FLL_ENGAGED_INTERNAL        = 7'h01;
  localparam [6:0] MODE_FLL_ENGAGED_EXTERNAL        = 7'h02;
  localparam [6:0] MODE_FLL_BYPASSED_INTERNAL       = 7'h04;
  localparam [6:0] MODE_BYPASSED_INTERNAL_LOW_POWER = 7'h08;
  localparam [6:0] MODE_FLL_BYPASSED_EXTERNAL       = 7'h10;
  localparam [6:0] MODE_BYPASSED_EXTERNAL_LOW_POWER = 7'h20;
  localparam [6:0] MODE_STOP                        = 7'h40;

  // Mode from control fields; reserved source code folds onto the FLL
  function [6:0] mode_decode;
    input [1:0] src;
    input       ref_internal;
    input       low_power;
    input       stop;
    begin
      if (stop) begin
        mode_decode = MODE_STOP;
      end else begin
        case (src)
          `FCS_SRC_INT: begin
            mode_decode = low_power ? MODE_BYPASSED_INTERNAL_LOW_POWER
                                    : MODE_FLL_BYPASSED_INTERNAL;
          end
          `FCS_SRC_EXT: begin
            mode_decode = low_power ? MODE_BYPASSED_EXTERNAL_LOW_POWER
                                    : MODE_FLL_BYPASSED_EXTERNAL;
          end
          default: begin
            mode_decode = ref_internal ? MODE_FLL_ENGAGED_INTERNAL
                                       : MODE_FLL_ENGAGED_EXTERNAL;
          end
        endcase
      end
    end
  endfunction

  // Reference divider shift; reserved high range codes stay at 1024
  function [3:0] ref_shift;
    input [2:0] code;
    input       high_range;
    reg   [3:0] raw;
    begin
      raw = {1'b0, code};
      if (high_range) begin
        raw = raw + `FCS_HIGH_RANGE_SHIFT;
      end
      ref_shift = (raw > `FCS_MAX_SHIFT) ? `FCS_MAX_SHIFT : raw;
    end
  endfunction

  reg  [7:0] src_ctrl_reg;
  reg  [7:0] osc_div_ctrl_reg;
  reg  [7:0] trim_reg;
  reg  [1:0] range_sel_reg;
  reg  [1:0] range_stat_reg;
  reg        max32_reg;
  reg        fine_trim_reg;
  reg  [1:0] src_stat_reg;
  reg        ref_stat_reg;
  reg  [6:0] mode_reg;
  reg  [6:0] mode_next;
  reg        keep_int_reg;
  reg        keep_ext_reg;
  reg  [7:0] rdata_next;

  wire [1:0] src_sel      = src_ctrl_reg[`FCS_SRC_SEL_HI:`FCS_SRC_SEL_LO];
  wire [2:0] ref_div      = src_ctrl_reg[`FCS_REF_DIV_HI:`FCS_REF_DIV_LO];
  wire       ref_internal = src_ctrl_reg[`FCS_REF_SEL_BIT];
  wire       iref_oe      = src_ctrl_reg[`FCS_IREF_OE_BIT];
  wire       iref_stop_en = src_ctrl_reg[`FCS_IREF_STOP_BIT];
  wire [1:0] bus_div_sel  = osc_div_ctrl_reg[`FCS_BUS_DIV_HI:`FCS_BUS_DIV_LO];
  wire       osc_range    = osc_div_ctrl_reg[`FCS_OSC_RANGE_BIT];
  wire       low_power    = osc_div_ctrl_reg[`FCS_LOW_POWER_BIT];
  wire       eref_oe      = osc_div_ctrl_reg[`FCS_EREF_OE_BIT];
  wire       eref_stop_en = osc_div_ctrl_reg[`FCS_EREF_STOP_BIT];
  wire [1:0] src_eff = (src_sel == `FCS_RANGE_RESERVED) ? `FCS_SRC_FLL
                                                         : src_sel;

  // Reference and oscillator inputs come from other domains
  wire [3:0] async_in = {oscillator_ready_in, dco_clk_in,
                         ext_ref_clk_in, int_ref_clk_in};
  wire [3:0] sync_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg [2:0] sh_reg;
      reg       lvl_reg;
      always @(posedge mclk) begin
        if (rst) begin
          sh_reg  <= 3'h0;
          lvl_reg <= 1'b0;
        end else begin
          sh_reg <= {sh_reg[1:0], async_in[gi]};
          if (sh_reg[1] == sh_reg[2]) begin
            lvl_reg <= sh_reg[2];
          end
        end
      end
      assign sync_lvl[gi] = lvl_reg;
    end
  endgenerate

  wire int_lvl   = sync_lvl[0];
  wire ext_lvl   = sync_lvl[1];
  wire dco_lvl   = sync_lvl[2];
  wire osc_ready = sync_lvl[3];

  // Mode state follows the control fields and the stop request
  always @* begin
    mode_next = mode_decode(src_sel, ref_internal, low_power,
                            stop_req);
  end

  always @(posedge mclk) begin
    if (rst) begin
      mode_reg <= MODE_FLL_ENGAGED_INTERNAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  reg       fll_on;
  reg       debug_on;
  reg       bus_run;
  always @* begin
    // Engaged and plain bypass modes run the FLL and the debug clock
    fll_on   = 1'b1;
    debug_on = 1'b1;
    bus_run  = 1'b1;
    case (mode_reg)
      MODE_BYPASSED_INTERNAL_LOW_POWER,
      MODE_BYPASSED_EXTERNAL_LOW_POWER: begin
        // An active debugger keeps the FLL alive for its clock
        fll_on   = debug_active;
        debug_on = debug_active;
      end
      MODE_STOP: begin
        fll_on   = 1'b0;
        debug_on = 1'b0;
        bus_run  = 1'b0;
      end
      default: begin
      end
    endcase
  end

  wire stop_now = (mode_reg == MODE_STOP);

  // Source mux ahead of the bus divider
  reg sel_lvl;
  always @* begin
    case (src_eff)
      `FCS_SRC_INT: sel_lvl = int_lvl;
      `FCS_SRC_EXT: sel_lvl = ext_lvl;
      default:      sel_lvl = dco_lvl;
    endcase
  end

  wire bus_div_clk;
  wire ref_div_clk;
  wire dbg_div_clk;

  fcs_clk_div u_bus_div (
    .mclk      (mclk),
    .rst       (rst),
    .src_level (sel_lvl),
    .shift     ({2'b00, bus_div_sel}),
    .clk_out   (bus_div_clk)
  );

  fcs_clk_div u_ref_div (
    .mclk      (mclk),
    .rst       (rst),
    .src_level (ext_lvl),
    .shift     (ref_shift(ref_div, osc_range)),
    .clk_out   (ref_div_clk)
  );

  fcs_clk_div u_dbg_div (
    .mclk      (mclk),
    .rst       (rst),
    .src_level (dco_lvl),
    .shift     (`FCS_DEBUG_SHIFT),
    .clk_out   (dbg_div_clk)
  );

  // Register writes
  always @(posedge mclk) begin
    if (rst) begin
      src_ctrl_reg     <= `FCS_RST_SRC_CTRL;
      osc_div_ctrl_reg <= `FCS_RST_OSC_DIV_CTRL;
      trim_reg         <= `FCS_RST_TRIM;
      range_sel_reg    <= `FCS_RST_RANGE;
      max32_reg        <= 1'b0;
      fine_trim_reg    <= `FCS_RST_FINE_TRIM;
    end else if (wr_stb) begin
      case (addr)
        `FCS_OFS_SRC_CTRL:     src_ctrl_reg     <= wdata;
        `FCS_OFS_OSC_DIV_CTRL: osc_div_ctrl_reg <= wdata;
        `FCS_OFS_TRIM:         trim_reg         <= wdata;
        `FCS_OFS_RANGE_STATUS: begin
          if (wdata[`FCS_RANGE_HI:`FCS_RANGE_LO] != `FCS_RANGE_RESERVED &&
              !low_power) begin
            range_sel_reg <= wdata[`FCS_RANGE_HI:`FCS_RANGE_LO];
          end
          max32_reg     <= wdata[`FCS_MAX32_BIT];
          fine_trim_reg <= wdata[`FCS_FINE_TRIM_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Status lags control by a cycle, as a clock crossing would
  always @(posedge mclk) begin
    if (rst) begin
      range_stat_reg <= `FCS_RST_RANGE;
      src_stat_reg   <= `FCS_SRC_FLL;
      ref_stat_reg   <= 1'b1;
    end else begin
      range_stat_reg <= range_sel_reg;
      src_stat_reg   <= src_eff;
      ref_stat_reg   <= ref_internal;
    end
  end

  // Keep decisions track the enables and freeze in stop, so the first
  // stop cycle already uses the setup from just before stop
  always @(posedge mclk) begin
    if (rst) begin
      keep_int_reg <= 1'b0;
      keep_ext_reg <= 1'b0;
    end else if (!stop_now) begin
      keep_int_reg <= iref_stop_en && iref_oe;
      keep_ext_reg <= eref_stop_en && eref_oe;
    end
  end

  wire int_out_on = stop_now ? keep_int_reg : iref_oe;
  wire ext_out_on = stop_now ? keep_ext_reg : eref_oe;
  wire ext_needed = !ref_internal || src_eff == `FCS_SRC_EXT || eref_oe;

  always @* begin
    rdata_next = 8'h00;
    if (rd_stb) begin
      case (addr)
        `FCS_OFS_SRC_CTRL:     rdata_next = src_ctrl_reg;
        `FCS_OFS_OSC_DIV_CTRL: rdata_next = osc_div_ctrl_reg;
        `FCS_OFS_TRIM:         rdata_next = trim_reg;
        default: begin
          rdata_next = {range_stat_reg, max32_reg, ref_stat_reg,
                        src_stat_reg, osc_ready, fine_trim_reg};
        end
      endcase
    end
  end

  // All outputs are registered here
  always @(posedge mclk) begin
    if (rst) begin
      rdata                       <= 8'h00;
      bus_clk_out                 <= 1'b0;
      debug_clk_out               <= 1'b0;
      fll_ref_clk_out             <= 1'b0;
      internal_ref_clock_out      <= 1'b0;
      external_ref_clock_out      <= 1'b0;
      fll_enable_out              <= 1'b0;
      fll_range_out               <= `FCS_RST_RANGE;
      max_freq_low_ref_option_out <= 1'b0;
      trim_out                    <= {`FCS_RST_TRIM, `FCS_RST_FINE_TRIM};
      int_ref_enable_out          <= 1'b0;
      osc_enable_out              <= 1'b0;
      osc_high_gain_out           <= 1'b0;
      osc_range_out               <= 1'b0;
      external_source_kind_out    <= 1'b0;
      mode_out                    <= MODE_FLL_ENGAGED_INTERNAL;
    end else begin
      rdata           <= rdata_next;
      bus_clk_out     <= bus_run && bus_div_clk;
      debug_clk_out   <= debug_on && dbg_div_clk;
      fll_ref_clk_out <= fll_on && (ref_internal ? int_lvl
                                                 : ref_div_clk);
      internal_ref_clock_out <= int_out_on && int_lvl;
      external_ref_clock_out <= ext_out_on && ext_lvl;
      fll_enable_out         <= fll_on;
      fll_range_out          <= range_stat_reg;
      max_freq_low_ref_option_out <= max32_reg;
      // Coarse trim is binary weighted: higher code, longer period
      trim_out <= {trim_reg, fine_trim_reg};
      int_ref_enable_out <= stop_now ? keep_int_reg : 1'b1;
      osc_enable_out     <= stop_now ? keep_ext_reg : ext_needed;
      osc_high_gain_out  <= osc_div_ctrl_reg[`FCS_HIGH_GAIN_BIT];
      osc_range_out      <= osc_range;
      external_source_kind_out <= osc_div_ctrl_reg[`FCS_EXT_KIND_BIT];
      mode_out           <= mode_reg;
    end
  end

endmodule // fcs_top

`default_nettype wire

// [verif/fcs_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module fcs_top_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       stop_req,
  input wire logic       debug_active,
  input wire logic       bus_clk_out,
  input wire logic       debug_clk_out,
  input wire logic       fll_ref_clk_out,
  input wire logic       internal_ref_clock_out,
  input wire logic       fll_enable_out,
  input wire logic [1:0] fll_range_out,
  input wire logic [8:0] trim_out,
  input wire logic [6:0] mode_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Output enable mirrored from bus writes, since registers are not ports
  logic oe_reg;
  always_ff @(posedge mclk)
    if (rst) oe_reg <= 1'b0;
    else if (wr_stb && addr == 2'h0) oe_reg <= wdata[1];

  a_reset_mode: assert property (
    $fell(rst) |-> mode_out == 7'h01 && trim_out == 9'h100)
    else $error("mode or trim wrong after reset");
  a_mode_onehot: assert property ($onehot(mode_out))
    else $error("mode not one-hot");
  a_stop_clocks: assert property (
    stop_req [*4] |-> !bus_clk_out && !debug_clk_out && mode_out == 7'h40)
    else $error("clock running in stop");
  a_stop_fll_off: assert property (
    stop_req [*4] |-> !fll_enable_out && !fll_ref_clk_out)
    else $error("fll running in stop");
  a_lp_no_debug: assert property (
    ((mode_out == 7'h08 || mode_out == 7'h20) && !debug_active) [*4]
    |-> !debug_clk_out && !fll_enable_out)
    else $error("debug clock in low power bypass");
  a_fll_on_modes: assert property (
    (mode_out == 7'h01 || mode_out == 7'h02 || mode_out == 7'h04 ||
     mode_out == 7'h10) [*4] |-> fll_enable_out)
    else $error("fll off in a running mode");
  a_iref_gated: assert property (
    !oe_reg [*4] |-> !internal_ref_clock_out)
    else $error("internal ref out while disabled");
  a_range_hold: assert property (
    wr_stb && addr == 2'h3 && wdata[7:6] == 2'h3
    |=> $stable(fll_range_out) [*3])
    else $error("reserved range code taken");
endmodule // fcs_top_checker

bind fcs_top fcs_top_checker fcs_top_checker_i (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .stop_req(stop_req), .debug_active(debug_active),
  .bus_clk_out(bus_clk_out), .debug_clk_out(debug_clk_out),
  .fll_ref_clk_out(fll_ref_clk_out),
  .internal_ref_clock_out(internal_ref_clock_out),
  .fll_enable_out(fll_enable_out), .fll_range_out(fll_range_out),
  .trim_out(trim_out), .mode_out(mode_out));
`default_nettype wire

// [verif/fcs_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module fcs_top_tb;
  logic       mclk, rst, wr_stb, rd_stb, stop_req, dbg;
  logic       iclk, eclk, dclk, bus, dbc, fref, iout, fen, mx;
  logic       eout, ien, oen, hg, orng, eks;
  logic [1:0] addr, rng;
  logic [7:0] wdata, rdata, rv;
  logic [6:0] mode;
  logic [8:0] trim;
  logic [3:0] tk = 4'h0;
  int         n_mismatch, compares;
  int         n [4];
  logic [7:0] c0 [7] = '{8'h00, 8'h44, 8'h44, 8'h80, 8'h80, 8'hc4, 8'h44};
  logic [7:0] c1 [7] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08};
  logic [6:0] em [7] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h01, 7'h08};
  int         eb [7] = '{192, 96, 96, 48, 48, 192, 96};
  int         ed [7] = '{96, 96, 0, 96, 0, 96, 96};
  int         ef [7] = '{48, 96, 0, 48, 0, 96, 96};

  fcs_top fcs_top_i (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .stop_req(stop_req),
    .debug_active(dbg), .int_ref_clk_in(iclk), .ext_ref_clk_in(eclk),
    .dco_clk_in(dclk), .oscillator_ready_in(1'b1), .bus_clk_out(bus),
    .debug_clk_out(dbc), .fll_ref_clk_out(fref),
    .internal_ref_clock_out(iout), .external_ref_clock_out(eout),
    .fll_enable_out(fen), .fll_range_out(rng),
    .max_freq_low_ref_option_out(mx), .trim_out(trim),
    .int_ref_enable_out(ien), .osc_enable_out(oen), .osc_high_gain_out(hg),
    .osc_range_out(orng), .external_source_kind_out(eks), .mode_out(mode));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Slow reference levels: periods of 4, 8 and 16 cycles survive the syncs
  always @(posedge mclk) tk <= tk + 4'h1;
  assign dclk = tk[1];
  assign iclk = tk[2];
  assign eclk = tk[3];

  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask
  // Rising edges of bus, debug, fll ref and internal ref out over a window
  task automatic meas;
    logic [3:0] p, c;
    n = '{0, 0, 0, 0};
    repeat (24) @(posedge mclk);
    #1 p = {bus, dbc, fref, iout};
    repeat (768) begin
      @(posedge mclk);
      #1 c = {bus, dbc, fref, iout};
      for (int j = 0; j < 4; j++) n[j] += int'(c[j] & ~p[j]);
      p = c;
    end
  endtask
  // Window edges make counts land one either side of the ideal figure
  function automatic int nr(int a, int e);
    return (a >= e - 1 && a <= e + 1) ? e : a;
  endfunction
  task automatic ex(input int b, input int d, input int f, input int i);
    chk(nr(n[3], b), b);
    chk(nr(n[2], d), d);
    chk(nr(n[1], f), f);
    chk(nr(n[0], i), i);
  endtask

  initial begin
    #400000;
    n_mismatch++;
    close_out;
  end

  initial begin
    {rst, wr_stb, rd_stb, stop_req, dbg} = 5'b10000;
    addr = 2'h0;
    wdata = 8'h00;
    n_mismatch = 0;
    compares = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(mode, 7'h01);
    chk(trim, 9'h100);
    rc(0, 8'h04);
    rc(1, 8'h40);
    rc(2, 8'h80);
    rc(3, 8'h12);
    meas;
    ex(96, 96, 96, 0);
    for (int k = 0; k < 7; k++) begin
      @(posedge mclk);
      dbg <= (k == 6);
      wr(0, c0[k]);
      wr(1, c1[k]);
      meas;
      chk(mode, em[k]);
      chk(fen, k != 2 && k != 4);
      ex(eb[k], ed[k], ef[k], 0);
      rd(3);
      chk(rv[3:2], c0[k][7:6] == 2'h3 ? 2'h0 : c0[k][7:6]);
    end
    @(posedge mclk);
    dbg <= 1'b0;
    wr(0, 8'h44);
    for (int k = 0; k < 4; k++) begin
      wr(1, 8'(k << 6));
      meas;
      ex(96 >> k, 96, 96, 0);
    end
    wr(1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(0, 8'(k << 3));
      meas;
      ex(192, 96, 48 >> k, 0);
    end
    // High range code 0 divides by 32: one or two edges in the window
    wr(0, 8'h00);
    wr(1, 8'h34);
    meas;
    ex(192, 96, 2, 0);
    chk({eout, ien, oen, hg, orng, eks}, 6'h1f);
    wr(0, 8'h47);
    meas;
    ex(96, 96, 96, 96);
    @(posedge mclk);
    stop_req <= 1'b1;
    meas;
    chk(mode, 7'h40);
    ex(0, 0, 0, 96);
    chk({eout, ien, oen}, 3'h2);
    @(posedge mclk);
    stop_req <= 1'b0;
    wr(0, 8'h46);
    stop_req <= 1'b1;
    meas;
    ex(0, 0, 0, 0);
    chk({eout, ien, oen}, 3'h0);
    @(posedge mclk);
    stop_req <= 1'b0;
    wr(2, 8'h3c);
    rc(2, 8'h3c);
    wr(3, 8'h40);
    repeat (4) @(posedge mclk);
    #1 chk(rng, 2'h1);
    wr(3, 8'hc0);
    wr(1, 8'h08);
    wr(3, 8'ha1);
    repeat (4) @(posedge mclk);
    #1 chk(rng, 2'h1);
    chk(trim, 9'h079);
    chk(mx, 1'b1);
    rd(3);
    chk(rv[7:5], 3'h3);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(mode, 7'h01);
    chk(trim, 9'h100);
    rc(1, 8'h40);
    close_out;
  end
endmodule // fcs_top_tb
`default_nettype wire
